/* logic/pid_top.sv */
// Phase interleave and maximum duty limit stage of the PWM controller
`timescale 1ns/10ps
`default_nettype none
`include "pid_defines.svh"

// Notes on behaviour
// - On-time starts a programmed phase delay after the sync line edge.
// - Phase steps are 11.25 degrees, independent of converter count.
// - Zero phase on all converters makes every on-time start at the sync edge.
// - Host writes interleave register; device applies that phase to PWM timing.
// - Duty cycle is clamped to the duty limit register value.
// - Five-bit code times 11.25 degrees gives phase lag, 00h to 1Fh.
// - Reset loads zero with mode input low, else five address bits.
// - Interleave register writes are ignored while the converter runs.
module pid_top #(
    parameter int CNT_W = `PID_CNT_W_DEFAULT
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   pwm_clk_in,
    input  wire logic                   sync_serial_line_in,
    input  wire logic                   interleave_mode_input_in,
    input  wire logic [4:0]             address_in,
    input  wire logic                   converter_on_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_sel_in,
    input  wire logic [7:0]             reg_wdata_in,
    output logic      [7:0]             reg_rdata_out,
    input  wire logic [`PID_DUTY_W-1:0] duty_cmd_in,
    output logic                        pwm_out
);
    // Elaboration check: the counter must resolve one duty step
    if (CNT_W < `PID_DUTY_W) begin : g_cnt_w_check
        $error("CNT_W must be at least the duty width");
    end

    // Host side registers and strap synchronisers
    logic [7:0]          interleave_reg;
    logic [7:0]          interleave_next;
    logic [7:0]          limit_reg;
    logic [7:0]          limit_next;
    logic                im_s1_reg;
    logic                im_s2_reg;
    logic [4:0]          addr_s1_reg;
    logic [4:0]          addr_s2_reg;
    logic                on_s1_reg;
    logic                on_s2_reg;
    pid_pkg::pid_cfg_type hold_reg;
    pid_pkg::pid_cfg_type hold_next;
    logic                req_reg;
    logic                req_next;
    logic                pend_reg;
    logic                pend_next;
    logic                ack_s1_reg;
    logic                ack_s2_reg;
    logic                cfg_write;
    logic                lreq_d_reg;

    always_ff @(posedge clk_in) begin
        im_s1_reg   <= interleave_mode_input_in;
        im_s2_reg   <= im_s1_reg;
        addr_s1_reg <= address_in;
        addr_s2_reg <= addr_s1_reg;
        on_s1_reg   <= converter_on_in;
        on_s2_reg   <= on_s1_reg;
    end

    always_comb begin
        cfg_write       = reg_wr_in && reg_sel_in == `PID_SEL_INTERLEAVE;
        interleave_next = interleave_reg;
        limit_next      = limit_reg;
        if (cfg_write && !on_s2_reg) begin
            interleave_next = reg_wdata_in;
        end
        if (reg_wr_in && reg_sel_in == `PID_SEL_DUTY_LIMIT) begin
            limit_next = reg_wdata_in;
        end
        // Offer a new snapshot only when the link side has acknowledged the last one
        hold_next = hold_reg;
        req_next  = req_reg;
        pend_next = pend_reg || interleave_next != interleave_reg || limit_next != limit_reg;
        if (pend_reg && req_reg == ack_s2_reg) begin
            hold_next.phase = interleave_reg[`PID_PHASE_LSB +: `PID_PHASE_W];
            hold_next.limit = limit_reg;
            req_next        = !req_reg;
            pend_next       = interleave_next != interleave_reg || limit_next != limit_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            interleave_reg <= {3'h0, im_s2_reg ? addr_s2_reg : 5'h00};
            limit_reg      <= `PID_DUTY_LIMIT_RESET;
            hold_reg       <= '0;
            req_reg        <= 1'b0;
            pend_reg       <= 1'b1;
            ack_s1_reg     <= 1'b0;
            ack_s2_reg     <= 1'b0;
        end else begin
            interleave_reg <= interleave_next;
            limit_reg      <= limit_next;
            hold_reg       <= hold_next;
            req_reg        <= req_next;
            pend_reg       <= pend_next;
            ack_s1_reg     <= lreq_d_reg;
            ack_s2_reg     <= ack_s1_reg;
        end
    end

    assign reg_rdata_out = (reg_sel_in == `PID_SEL_DUTY_LIMIT) ? limit_reg : interleave_reg;

    // Link side: PLL clock domain
    logic                 lrst_s1_reg;
    logic                 lrst_s2_reg;
    logic                 sync_s1_reg;
    logic                 sync_s2_reg;
    logic                 sync_d_reg;
    logic                 run_s1_reg;
    logic                 run_s2_reg;
    logic                 lreq_s1_reg;
    logic                 lreq_s2_reg;
    logic                 cyc_start;
    logic                 en_reg;
    logic                 en_next;
    pid_pkg::pid_cfg_type shadow_reg;
    pid_pkg::pid_cfg_type shadow_next;
    pid_pkg::pid_cfg_type act_reg;
    pid_pkg::pid_cfg_type act_next;
    logic [CNT_W-1:0]     cnt_reg;
    logic [CNT_W-1:0]     cnt_next;
    logic [`PID_DUTY_W-1:0] duty_reg;
    logic [`PID_DUTY_W-1:0] duty_next;
    logic                 pwm_next;
    logic                 sync_edge;
    logic [`PID_DUTY_W-1:0] duty_eff;
    logic [CNT_W-1:0]     pos;
    logic [CNT_W-1:0]     pos_next;

    function automatic logic [CNT_W-1:0] pid_offset(input logic [4:0] code);
        pid_offset = CNT_W'(code) << (CNT_W - `PID_PHASE_W);
    endfunction

    always_ff @(posedge pwm_clk_in) begin
        lrst_s1_reg <= rst_n_in;
        lrst_s2_reg <= lrst_s1_reg;
        sync_s1_reg <= sync_serial_line_in;
        sync_s2_reg <= sync_s1_reg;
        run_s1_reg  <= converter_on_in;
        run_s2_reg  <= run_s1_reg;
        lreq_s1_reg <= req_reg;
        lreq_s2_reg <= lreq_s1_reg;
    end

    always_comb begin
        sync_edge   = sync_s2_reg && !sync_d_reg;
        shadow_next = (lreq_s2_reg != lreq_d_reg) ? hold_reg : shadow_reg;
        pos         = cnt_reg - pid_offset(act_reg.phase);
        // Counter restarts on each synchronising edge of the master clock
        cnt_next    = sync_edge ? '0 : cnt_reg + CNT_W'(1);
        act_next    = act_reg;
        pos_next    = cnt_next - pid_offset(act_reg.phase);
        cyc_start   = pos_next == '0;
        if (cyc_start) begin
            act_next = shadow_reg;
            pos_next = cnt_next - pid_offset(shadow_reg.phase);
        end
        duty_eff  = (duty_cmd_in > act_next.limit) ? act_next.limit : duty_cmd_in;
        // A phase change skips the on-time until the new phase point comes round
        duty_next = duty_reg;
        if (pos_next == '0) begin
            duty_next = duty_eff;
        end else if (cyc_start) begin
            duty_next = '0;
        end
        // Output only switches on at a cycle start, never part way into an on-time
        en_next   = run_s2_reg && (en_reg || pos_next == '0);
        pwm_next  = en_next && (pos_next[CNT_W-1 -: `PID_DUTY_W] < duty_next);
    end

    always_ff @(posedge pwm_clk_in) begin
        if (!lrst_s2_reg) begin
            sync_d_reg <= 1'b0;
            lreq_d_reg <= 1'b0;
            en_reg     <= 1'b0;
            shadow_reg <= '0;
            act_reg    <= '0;
            cnt_reg    <= '0;
            duty_reg   <= '0;
            pwm_out    <= 1'b0;
        end else begin
            sync_d_reg <= sync_s2_reg;
            lreq_d_reg <= lreq_s2_reg;
            en_reg     <= en_next;
            shadow_reg <= shadow_next;
            act_reg    <= act_next;
            cnt_reg    <= cnt_next;
            duty_reg   <= duty_next;
            pwm_out    <= pwm_next;
        end
    end

    // Host side checks
    property p_locked_write;
        @(posedge clk_in) disable iff (!rst_n_in)
        cfg_write && on_s2_reg |=> $stable(interleave_reg);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("write while running took");

    property p_cfg_write;
        @(posedge clk_in) disable iff (!rst_n_in)
        cfg_write && !on_s2_reg |=> interleave_reg == $past(reg_wdata_in);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("interleave write lost");

    property p_limit_write;
        @(posedge clk_in) disable iff (!rst_n_in)
        reg_wr_in && reg_sel_in == `PID_SEL_DUTY_LIMIT ##1 !reg_wr_in
        |-> reg_rdata_out == $past(reg_wdata_in, 1) || reg_sel_in != `PID_SEL_DUTY_LIMIT;
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("limit write lost");

    property p_strap;
        @(posedge clk_in)
        $rose(rst_n_in) |-> interleave_reg[4:0] == ($past(im_s2_reg) ? $past(addr_s2_reg) : 5'h00);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded at reset");

    // Link side checks
    property p_clamp;
        @(posedge pwm_clk_in) disable iff (!lrst_s2_reg)
        duty_reg <= act_reg.limit;
    endproperty
    a_clamp: assert property (p_clamp) else $error("duty above limit");

    property p_cycle_load;
        @(posedge pwm_clk_in) disable iff (!lrst_s2_reg)
        $changed(duty_reg) || $changed(act_reg) |-> pos == '0 || $past(cyc_start);
    endproperty
    a_cycle_load: assert property (p_cycle_load) else $error("setting changed mid cycle");

    property p_start_phase;
        @(posedge pwm_clk_in) disable iff (!lrst_s2_reg)
        $rose(pwm_out) |-> pos == '0;
    endproperty
    a_start_phase: assert property (p_start_phase) else $error("on-time not at phase point");

    property p_zero_phase;
        @(posedge pwm_clk_in) disable iff (!lrst_s2_reg)
        sync_edge && act_reg.phase == 5'h00 && shadow_reg.phase == 5'h00
            && run_s2_reg && duty_eff != '0 |=> pwm_out && cnt_reg == '0;
    endproperty
    a_zero_phase: assert property (p_zero_phase) else $error("zero phase not at sync edge");
endmodule
`default_nettype wire

/* logic/pid_defines.svh */
// Register selects, reset values and timing constants of the interleave and duty limit block
`ifndef PID_DEFINES_SVH
`define PID_DEFINES_SVH

`define PID_SEL_INTERLEAVE   1'b0
`define PID_SEL_DUTY_LIMIT   1'b1
`define PID_INTERLEAVE_RESET 8'h00
`define PID_DUTY_LIMIT_RESET 8'he8
`define PID_PHASE_LSB        0
`define PID_PHASE_W          5
`define PID_FREQ_LSB         5
`define PID_FREQ_W           3
`define PID_DUTY_W           8
`define PID_PHASE_STEP_MDEG  11250
`define PID_CNT_W_DEFAULT    8

`endif

/* logic/pid_pkg.sv */
// Types shared by the interleave and duty limit block
package pid_pkg;
    typedef struct packed {
        logic [4:0] phase;
        logic [7:0] limit;
    } pid_cfg_type;
endpackage

/* bench/pid_power_manager.sv */
// Power manager model: free running master sync line on the PLL clock
`timescale 1ns/10ps
`default_nettype none
module pid_power_manager (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    output logic            sync_out,
    output logic      [7:0] pos_out
);
    logic [7:0] pos_reg;
    logic [7:0] pos_next;
    always_comb begin
        pos_next = rst_n_in ? pos_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk_in) begin
        pos_reg <= pos_next;
    end
    assign pos_out  = pos_reg;
    // Rising edge once every 256 clocks, when the position wraps to 0
    assign sync_out = ~pos_reg[7];
endmodule
`default_nettype wire

/* bench/test_pid_top.sv */
// Self-checking bench for the interleave and duty limit stage
`timescale 1ns/10ps
`default_nettype none
`include "pid_defines.svh"
module test_pid_top;
    typedef struct {int phase; int width;} pid_note_type;
    logic         clk, pclk, rst_n, sync, im, on, wr, sel, pwm, busy, pwm_d;
    logic   [4:0] addr;
    logic   [7:0] wdata, rdata, duty, pos;
    int           bad_count, n_tests, off, wid, base;
    pid_note_type nq[$];

    pid_top #(.CNT_W(8)) u_pid_top (.clk_in(clk), .rst_n_in(rst_n), .pwm_clk_in(pclk),
        .sync_serial_line_in(sync), .interleave_mode_input_in(im), .address_in(addr),
        .converter_on_in(on), .reg_wr_in(wr), .reg_sel_in(sel), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .duty_cmd_in(duty), .pwm_out(pwm));
    pid_power_manager u_pid_power_manager (.clk_in(pclk), .rst_n_in(rst_n),
        .sync_out(sync), .pos_out(pos));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: seen %0h expected %0h", $time, m, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic s, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        sel = s;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic s, input logic [7:0] exp);
        @(negedge clk);
        sel = s;
        @(negedge clk);
        check(rdata, exp, "register read");
    endtask
    // Reprogram while stopped, restart, then note the expected pulse
    task automatic pulse(input int ph, input int d, input int lim);
        int k;
        on = 1'b0;
        repeat (4) @(negedge clk);
        wr_reg(1'b0, 8'(ph));
        wr_reg(1'b1, 8'(lim));
        rd_reg(1'b0, 8'(ph));
        duty = 8'(d);
        on = 1'b1;
        repeat (160) @(negedge clk);
        nq.push_back('{ph, (d < lim) ? d : lim});
        for (k = 0; k < 400 && nq.size() > 0; k++) @(negedge clk);
        if (nq.size() > 0) begin
            bad_count++;
            end_sim();
        end else begin
            $display("test phase %0d duty %0d limit %0d done", ph, d, lim);
        end
    endtask

    // Measures each on-time from the sync edge once a note is waiting
    // Sampled on the falling edge; a tail left from the previous period is skipped
    always @(negedge pclk) begin
        if (busy && pwm === 1'b1 && (off >= 0 || pwm_d === 1'b0)) begin
            if (off < 0) off = pos;
            wid++;
        end else if (busy && pwm !== 1'b1 && (off >= 0 || pos == 8'hff)) begin
            check(off >= 0, 1, "pulse seen");
            if (nq[0].phase == 0) base = off;
            if (nq[0].phase == 0) check(base <= 8, 1, "zero phase start");
            check(off, base + 8 * nq[0].phase, "on-time phase");
            check(wid, nq[0].width, "on-time width");
            void'(nq.pop_front());
            busy = 1'b0;
        end else if (!busy && pos == 8'h00 && nq.size() > 0) begin
            busy = 1'b1;
            off = -1;
            wid = 0;
        end
        pwm_d = pwm;
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        pclk = 1'b0;
        #3;
        forever #6 pclk = ~pclk;
    end
    initial begin
        int ph[5] = '{0, 1, 9, 16, 30};
        bad_count = 0; n_tests = 0; busy = 1'b0; base = 0; off = -1; wid = 0;
        rst_n = 1'b0; im = 1'b1; addr = 5'h13; on = 1'b0;
        wr = 1'b0; sel = 1'b0; wdata = 8'h00; duty = 8'h00;
        void'($urandom(32'h8048));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(1'b0, 8'h13);
        rd_reg(1'b1, `PID_DUTY_LIMIT_RESET);
        $display("test reset values done");
        wr_reg(1'b1, 8'h80);
        rd_reg(1'b1, 8'h80);
        on = 1'b1;
        repeat (4) @(negedge clk);
        wr_reg(1'b0, 8'h1f);
        rd_reg(1'b0, 8'h13);
        $display("test write while running done");
        foreach (ph[i]) pulse(ph[i], $urandom_range(100, 1), (i == 2) ? 40 : 232);
        on = 1'b0;
        rst_n = 1'b0;
        im = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(1'b0, 8'h00);
        $display("test strap low reset done");
        end_sim();
    end
endmodule
`default_nettype wire
